// file: core/contactless_uart_framer.v
`timescale 1ns/10ps
`default_nettype none
`include "cl_framer_defines.vh"
module contactless_uart_framer (
  input wire clk_in, // 50 MHz clock
  input wire rst_in, // Async reset, active high
  input wire dir_tx_in, // 1: host fills FIFO for transmit
  input wire start_tx_in, // Pulse: send FIFO contents
  input wire flush_in, // Pulse: empty FIFO
  input wire card_mode_in, // 1: card emulation, 0: reader
  input wire [1:0] rate_in, // Bit rate select
  input wire crypto_en_in, // Enable stream encryption (reader mode only; ignored when card_mode_in is 1)
  input wire [47:0] crypto_key_in, // Stream key
  input wire fast_we_in, // Fast register write strobe
  input wire [3:0] fast_addr_in, // Fast register index
  input wire [7:0] fast_wdata_in, // Fast register data
  input wire host_wr_in, // Host writes a byte
  input wire [7:0] host_wdata_in, // Host byte
  input wire host_rd_in, // Host reads a byte
  input wire rx_bit_in, // Demodulated bit from front end (pin)
  input wire rx_valid_in, // Demodulated bit strobe (pin)
  input wire carrier_in, // Carrier seen at receive input (pin)
  input wire [1:0] scheme_in, // Signalling scheme seen (pin)
  input wire sc_rx_in, // Secure-core link receive (pin)
  output reg [7:0] host_rdata_out, // Byte read by host
  output reg fifo_empty_out, // FIFO empty
  output reg fifo_full_out, // FIFO full
  output reg [7:0] fast_rdata_out, // Fast register read data
  output reg tx_bit_out, // Serial bit to modulator
  output reg tx_active_out, // Frame being sent
  output reg load_mod_out, // Load-modulation drive
  output reg sc_tx_out, // Secure-core link transmit
  output reg sc_rx_out, // Secure-core receive, re-timed
  output reg field_on_out, // External field present
  output reg [1:0] rx_scheme_out, // Receiver scheme configured
  output reg parity_err_out, // Sticky parity error
  output reg crc_err_out, // Sticky CRC error
  output reg rx_done_out // Pulse: frame received
);
  localparam ST_IDLE = 2'h0;
  localparam ST_DATA = 2'h1;
  localparam ST_PAR = 2'h2;
  localparam ST_CRC = 2'h3;
  // Pin synchronisers: three stages, change taken when stages two and three agree
  reg [2:0] rxb_s, rxv_s, car_s, scr_s;
  reg [1:0] sch_s0, sch_s1, sch_s2;
  reg rxb_q, rxv_q, car_q, scr_q, rxv_prev_q;
  reg [1:0] sch_q;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rxb_s <= 3'h0; rxv_s <= 3'h0; car_s <= 3'h0; scr_s <= 3'h0;
      sch_s0 <= 2'h0; sch_s1 <= 2'h0; sch_s2 <= 2'h0;
      rxb_q <= 1'b0; rxv_q <= 1'b0; car_q <= 1'b0; scr_q <= 1'b0;
      sch_q <= 2'h0; rxv_prev_q <= 1'b0;
    end else begin
      rxb_s <= {rxb_s[1:0], rx_bit_in};
      rxv_s <= {rxv_s[1:0], rx_valid_in};
      car_s <= {car_s[1:0], carrier_in};
      scr_s <= {scr_s[1:0], sc_rx_in};
      sch_s0 <= scheme_in; sch_s1 <= sch_s0; sch_s2 <= sch_s1;
      if (rxb_s[1] == rxb_s[2]) rxb_q <= rxb_s[2];
      if (rxv_s[1] == rxv_s[2]) rxv_q <= rxv_s[2];
      if (car_s[1] == car_s[2]) car_q <= car_s[2];
      if (scr_s[1] == scr_s[2]) scr_q <= scr_s[2];
      if (sch_s1 == sch_s2) sch_q <= sch_s2;
      rxv_prev_q <= rxv_q;
    end
  end
  wire rx_strobe = rxv_q && !rxv_prev_q;
  // Sixteen fast-access registers; the other registers live outside this block
  reg [7:0] fast_q [0:`FAST_REG_COUNT-1];
  genvar gi;
  generate
    for (gi = 0; gi < `FAST_REG_COUNT; gi = gi + 1) begin : g_fast
      always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) fast_q[gi] <= 8'h00;
        else if (fast_we_in && fast_addr_in == gi) fast_q[gi] <= fast_wdata_in;
      end
    end
  endgenerate
  // Shared FIFO: host or engine fills, the other drains
  reg eng_wr_q, eng_rd_d;
  reg [7:0] eng_wdata_q;
  wire f_wr = dir_tx_in ? host_wr_in : eng_wr_q;
  wire [7:0] f_wdata = dir_tx_in ? host_wdata_in : eng_wdata_q;
  wire f_rd = dir_tx_in ? eng_rd_d : host_rd_in;
  wire [7:0] f_rdata;
  wire f_empty, f_full;
  cl_byte_fifo u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .flush_in(flush_in),
    .wr_in(f_wr),
    .wdata_in(f_wdata),
    .rd_in(f_rd),
    .rdata_out(f_rdata),
    .empty_out(f_empty),
    .full_out(f_full),
    .level_out()
  );
  // CRC over one byte, LSB first, reflected polynomial
  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0] d;
    integer k;
    reg [15:0] x;
    begin
      x = c ^ {8'h00, d};
      for (k = 0; k < 8; k = k + 1) begin
        x = x[0] ? ((x >> 1) ^ 16'h8408) : (x >> 1);
      end
      crc_byte = x;
    end
  endfunction
  // Keystream: 48-bit LFSR, one bit per data bit
  reg [47:0] lfsr_q;
  wire ks = lfsr_q[0] ^ lfsr_q[5] ^ lfsr_q[9] ^ lfsr_q[47];
  wire crypt_on = crypto_en_in && !card_mode_in;
  // Bit-rate enable divider
  reg [7:0] div_q;
  reg [7:0] div_max;
  always @* begin
    case (rate_in)
      `RATE_106: div_max = `DIV_106;
      `RATE_212: div_max = `DIV_212;
      default: div_max = `DIV_424;
    endcase
  end
  wire bit_en = (div_q == 8'h00);
  // Transmit and receive engine
  reg [1:0] tst_q, rst_q;
  reg [2:0] tbit_q, rbit_q;
  reg [7:0] tsh_q, rsh_q;
  reg tpar_q, rpar_q;
  reg [15:0] tcrc_q, rcrc_q;
  reg [4:0] tcrcn_q;
  reg [7:0] field_cnt_q;
  always @* begin
    eng_rd_d = dir_tx_in && tst_q == ST_IDLE && tx_active_out && !f_empty;
  end
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_q <= 8'h00; tst_q <= ST_IDLE; rst_q <= ST_IDLE;
      tbit_q <= 3'h0; rbit_q <= 3'h0; tsh_q <= 8'h00; rsh_q <= 8'h00;
      tpar_q <= 1'b0; rpar_q <= 1'b0; tcrc_q <= `CRC_PRESET; rcrc_q <= `CRC_PRESET;
      tcrcn_q <= 5'h00; lfsr_q <= 48'h0; field_cnt_q <= 8'h00;
      eng_wr_q <= 1'b0; eng_wdata_q <= 8'h00;
      host_rdata_out <= 8'h00; fifo_empty_out <= 1'b1; fifo_full_out <= 1'b0;
      fast_rdata_out <= 8'h00; tx_bit_out <= 1'b0; tx_active_out <= 1'b0;
      load_mod_out <= 1'b0; sc_tx_out <= 1'b0; sc_rx_out <= 1'b0;
      field_on_out <= 1'b0; rx_scheme_out <= `DM_NONE;
      parity_err_out <= 1'b0; crc_err_out <= 1'b0; rx_done_out <= 1'b0;
    end else begin
      div_q <= bit_en ? div_max : div_q - 8'h01;
      eng_wr_q <= 1'b0;
      rx_done_out <= 1'b0;
      host_rdata_out <= f_rdata;
      fifo_empty_out <= f_empty;
      fifo_full_out <= f_full;
      fast_rdata_out <= fast_q[fast_addr_in];
      sc_rx_out <= scr_q;
      // Field detector with a short debounce count
      if (!car_q) begin
        field_cnt_q <= 8'h00;
        field_on_out <= 1'b0;
      end else if (field_cnt_q != `FIELD_ON_COUNT) begin
        field_cnt_q <= field_cnt_q + 8'h01;
      end else begin
        field_on_out <= 1'b1;
      end
      // Receiver configured from detected scheme while idle
      if (rst_q == ST_IDLE) rx_scheme_out <= sch_q;
      if (start_tx_in && !tx_active_out) begin
        tx_active_out <= 1'b1;
        tcrc_q <= `CRC_PRESET;
        tcrcn_q <= 5'h00;
        lfsr_q <= crypto_key_in;
        parity_err_out <= 1'b0;
        crc_err_out <= 1'b0;
      end
      // Transmit: byte, odd parity, then two CRC bytes
      if (eng_rd_d) begin
        tsh_q <= f_rdata;
        tpar_q <= ~^f_rdata;
        tcrc_q <= crc_byte(tcrc_q, f_rdata);
        tbit_q <= 3'h0;
        tst_q <= ST_DATA;
      end else if (tst_q == ST_IDLE && tx_active_out && f_empty && dir_tx_in) begin
        if (tcrcn_q == 5'h00) begin
          tsh_q <= tcrc_q[7:0]; tpar_q <= ~^tcrc_q[7:0];
          tcrcn_q <= 5'h01; tbit_q <= 3'h0; tst_q <= ST_CRC;
        end else if (tcrcn_q == 5'h01) begin
          tsh_q <= tcrc_q[15:8]; tpar_q <= ~^tcrc_q[15:8];
          tcrcn_q <= 5'h02; tbit_q <= 3'h0; tst_q <= ST_CRC;
        end else begin
          tx_active_out <= 1'b0;
          tx_bit_out <= 1'b0;
          load_mod_out <= 1'b0;
          sc_tx_out <= 1'b0;
        end
      end else if (bit_en && (tst_q == ST_DATA || tst_q == ST_CRC)) begin
        tx_bit_out <= tsh_q[0] ^ (crypt_on & ks);
        load_mod_out <= card_mode_in & (tsh_q[0] ^ (crypt_on & ks));
        sc_tx_out <= (rate_in == `RATE_EXT) ? tsh_q[0] : 1'b0;
        lfsr_q <= {lfsr_q[46:0], ks};
        tsh_q <= {1'b0, tsh_q[7:1]};
        tbit_q <= tbit_q + 3'h1;
        if (tbit_q == 3'h7) tst_q <= ST_PAR;
      end else if (bit_en && tst_q == ST_PAR) begin
        tx_bit_out <= tpar_q;
        load_mod_out <= card_mode_in & tpar_q;
        tst_q <= ST_IDLE;
      end
      // Receive: byte then parity bit; CRC accumulated on every byte, checked at frame end
      if (rx_strobe && !dir_tx_in) begin
        if (rst_q != ST_PAR) begin
          rsh_q <= {rxb_q ^ (crypt_on & ks), rsh_q[7:1]};
          rbit_q <= rbit_q + 3'h1;
          rst_q <= (rbit_q == 3'h7) ? ST_PAR : ST_DATA;
          if (crypt_on) lfsr_q <= {lfsr_q[46:0], ks};
        end else begin
          rpar_q <= rxb_q;
          if (rxb_q != ~^rsh_q) parity_err_out <= 1'b1;
          rcrc_q <= crc_byte(rcrc_q, rsh_q);
          eng_wr_q <= 1'b1;
          eng_wdata_q <= rsh_q;
          rst_q <= ST_CRC;
        end
      end else if (!car_q && rst_q == ST_CRC) begin
        // Stay between bytes until the carrier goes, so the frame end below can see it
        rst_q <= ST_IDLE;
      end
      // Frame end: carrier lost while the receiver waits between bytes closes the frame
      if (!dir_tx_in && rst_q == ST_CRC && !car_q) begin
        if (rcrc_q != 16'h0000) crc_err_out <= 1'b1;
        rcrc_q <= `CRC_PRESET;
        rx_done_out <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: core/cl_framer_defines.vh
// Overview of operation
// - Type A framing: parity appended and checked
// - CRC coprocessor, Type A polynomial and preset
// - One 64-byte FIFO, both directions
// - Engine shares protocol duties with host
// - Sixteen fast registers in special space
// - Type A at 212 and 424 kbit/s
// - Field detector flags external carrier present
// - Data-mode detector selects receiver scheme
// - Card mode drives load-modulation output
// - Secure-core link carries digital tx/rx
// - Reader mode applies stream encryption
`ifndef CL_FRAMER_DEFINES_VH
`define CL_FRAMER_DEFINES_VH
`define FIFO_DEPTH 64
`define FIFO_AW 6
`define CRC_POLY 16'h1021
`define CRC_PRESET 16'h6363
`define FAST_REG_COUNT 16
`define RATE_106 2'h0
`define RATE_212 2'h1
`define RATE_424 2'h2
`define RATE_EXT 2'h3
`define DIV_106 8'h1D
`define DIV_212 8'h0E
`define DIV_424 8'h07
`define DM_NONE 2'h0
`define DM_TYPEA 2'h1
`define DM_MANCH 2'h2
`define DM_NFC 2'h3
`define FIELD_ON_COUNT 8'h20
`endif

// file: core/cl_byte_fifo.v
`timescale 1ns/10ps
`default_nettype none
`include "cl_framer_defines.vh"
module cl_byte_fifo #(
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW = `FIFO_AW
) (
  input wire clk_in, // Clock
  input wire rst_in, // Async reset
  input wire flush_in, // Empty the buffer
  input wire wr_in, // Write request
  input wire [7:0] wdata_in, // Write byte
  input wire rd_in, // Read request
  output wire [7:0] rdata_out, // Head byte
  output wire empty_out, // No bytes held
  output wire full_out, // All entries used
  output wire [AW:0] level_out // Bytes held
);
  reg [7:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire do_wr;
  wire do_rd;
  // Refused accesses leave pointers and storage untouched
  assign do_wr = wr_in && (cnt_q != DEPTH);
  assign do_rd = rd_in && (cnt_q != {(AW+1){1'b0}});
  assign rdata_out = mem[rp_q];
  assign empty_out = (cnt_q == {(AW+1){1'b0}});
  assign full_out = (cnt_q == DEPTH);
  assign level_out = cnt_q;
  // Storage write, no reset needed for data
  always @(posedge clk_in) begin
    if (do_wr) begin
      mem[wp_q] <= wdata_in;
    end
  end
  // Pointers and count
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (flush_in) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wp_q <= wp_q + 1'b1;
      end
      if (do_rd) begin
        rp_q <= rp_q + 1'b1;
      end
      if (do_wr && !do_rd) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/cl_framer_properties.sv
`timescale 1ns/10ps
`default_nettype none
module cl_framer_properties (
  input wire logic clk_in, // Clock
  input wire logic rst_in, // Async reset
  input wire logic dir_tx_in, // Direction
  input wire logic start_tx_in, // Send pulse
  input wire logic flush_in, // Flush pulse
  input wire logic host_wr_in, // Host write
  input wire logic host_rd_in, // Host read
  input wire logic carrier_in, // Carrier pin
  input wire logic fifo_empty_out, // Empty flag
  input wire logic fifo_full_out, // Full flag
  input wire logic tx_active_out, // Sending
  input wire logic field_on_out, // Field flag
  input wire logic parity_err_out, // Parity error
  input wire logic crc_err_out, // CRC error
  input wire logic rx_done_out // Frame done
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  AST_NOT_BOTH: assert property (!(fifo_empty_out && fifo_full_out))
    else $error("empty and full together");
  // Flags are registered, so they answer one cycle after the buffer itself
  AST_WR_FILLS: assert property (host_wr_in && dir_tx_in && !flush_in && !tx_active_out |=> ##1 !fifo_empty_out)
    else $error("write left buffer empty");
  AST_FULL_HOLDS: assert property (fifo_full_out && dir_tx_in && !host_rd_in && !flush_in && !$past(flush_in) && !start_tx_in
    && !tx_active_out |=> fifo_full_out)
    else $error("full flag dropped without a read");
  AST_EMPTY_HOLDS: assert property (fifo_empty_out && dir_tx_in && !host_wr_in && !$past(host_wr_in) |=> fifo_empty_out)
    else $error("empty flag dropped without a write");
  AST_FLUSH: assert property (flush_in && !host_wr_in |=> ##1 fifo_empty_out)
    else $error("flush did not empty buffer");
  AST_TX_START: assert property (start_tx_in && dir_tx_in && !fifo_empty_out && !tx_active_out |=> tx_active_out)
    else $error("transmit did not start");
  AST_ERR_CLEAR: assert property (start_tx_in && !tx_active_out |=> !parity_err_out && !crc_err_out)
    else $error("error flags not cleared by start");
  AST_DONE_PULSE: assert property (rx_done_out |=> !rx_done_out)
    else $error("frame done longer than one cycle");
  // Debounce needs a long run of carrier, so a quiet carrier forbids a rise
  AST_FIELD_QUIET: assert property (!carrier_in [*8] |=> !$rose(field_on_out))
    else $error("field flag rose without carrier");
endmodule
bind contactless_uart_framer cl_framer_properties chk (.clk_in(clk_in), .rst_in(rst_in), .dir_tx_in(dir_tx_in),
  .start_tx_in(start_tx_in), .flush_in(flush_in), .host_wr_in(host_wr_in), .host_rd_in(host_rd_in),
  .carrier_in(carrier_in), .fifo_empty_out(fifo_empty_out), .fifo_full_out(fifo_full_out),
  .tx_active_out(tx_active_out), .field_on_out(field_on_out), .parity_err_out(parity_err_out),
  .crc_err_out(crc_err_out), .rx_done_out(rx_done_out));
`default_nettype wire

// file: tb/cl_front_end_model.sv
`timescale 1ns/10ps
`default_nettype none
module cl_front_end_model (
  input wire logic clk_in, // Bench clock
  output logic carrier_out, // Field present
  output logic bit_out, // Demodulated bit
  output logic valid_out, // Bit strobe
  output logic [1:0] scheme_out, // Scheme seen
  output logic sc_rx_out // Secure-core line, idle high
);
  initial begin
    carrier_out = 1'b0;
    bit_out = 1'b0;
    valid_out = 1'b0;
    scheme_out = 2'h1;
    sc_rx_out = 1'b1;
  end
  // One byte frame: carrier, byte LSB first, odd parity, carrier off
  task automatic frame(input logic [7:0] b, input logic bad);
    logic [8:0] f;
    f = {~^b ^ bad, b};
    carrier_out = 1'b1;
    repeat (48) @(negedge clk_in);
    for (int i = 0; i < 9; i++) begin
      bit_out = f[i];
      valid_out = 1'b1;
      // Two cycles, since the pin filter ignores a single-cycle pulse
      repeat (2) @(negedge clk_in);
      valid_out = 1'b0;
      repeat (5) @(negedge clk_in);
    end
    bit_out = ~bit_out; // Released line must not echo the last bit
    repeat (8) @(negedge clk_in);
    carrier_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_contactless_uart_framer.sv
`timescale 1ns/10ps
`default_nettype none
`include "cl_framer_defines.vh"
module tb_contactless_uart_framer;
  logic clk_in = 0, rst_in = 1, dir_tx_in = 1, start_tx_in = 0, flush_in = 0, card_mode_in = 0, crypto_en_in = 0;
  logic fast_we_in = 0, host_wr_in = 0, host_rd_in = 0, field_seen = 0;
  logic [1:0] rate_in = 2'h0;
  logic [47:0] crypto_key_in = 48'h0;
  logic [3:0] fast_addr_in = 4'h0;
  logic [7:0] fast_wdata_in = 8'h00, host_wdata_in = 8'h00, b;
  logic [7:0] q[$];
  logic [7:0] regs[16];
  wire rx_bit_in, rx_valid_in, carrier_in, sc_rx_in, fifo_empty_out, fifo_full_out, tx_bit_out, tx_active_out;
  wire load_mod_out, sc_tx_out, sc_rx_out, field_on_out, parity_err_out, crc_err_out, rx_done_out;
  wire [1:0] scheme_in, rx_scheme_out;
  wire [7:0] host_rdata_out, fast_rdata_out;
  int fails = 0, check_count = 0, done_cnt = 0, n, d, seed;
  contactless_uart_framer dut (.clk_in, .rst_in, .dir_tx_in, .start_tx_in, .flush_in, .card_mode_in, .rate_in,
    .crypto_en_in, .crypto_key_in, .fast_we_in, .fast_addr_in, .fast_wdata_in, .host_wr_in, .host_wdata_in,
    .host_rd_in, .rx_bit_in, .rx_valid_in, .carrier_in, .scheme_in, .sc_rx_in, .host_rdata_out, .fifo_empty_out,
    .fifo_full_out, .fast_rdata_out, .tx_bit_out, .tx_active_out, .load_mod_out, .sc_tx_out, .sc_rx_out,
    .field_on_out, .rx_scheme_out, .parity_err_out, .crc_err_out, .rx_done_out);
  cl_front_end_model fe (.clk_in(clk_in), .carrier_out(carrier_in), .bit_out(rx_bit_in), .valid_out(rx_valid_in),
    .scheme_out(scheme_in), .sc_rx_out(sc_rx_in));
  initial forever #10 clk_in = ~clk_in;
  // Pulses and levels are short, so watch them every edge
  always @(negedge clk_in) begin
    if (rx_done_out === 1'b1) done_cnt++;
    if (field_on_out === 1'b1) field_seen = 1'b1;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Model keeps at most 64 bytes; a write beyond that is dropped
  task automatic wr(input logic [7:0] v);
    host_wdata_in = v;
    host_wr_in = 1'b1;
    @(negedge clk_in);
    host_wr_in = 1'b0;
    if (q.size() < 64) q.push_back(v);
  endtask
  task automatic rd;
    repeat (2) @(negedge clk_in);
    if (q.size() > 0) check(host_rdata_out, q[0]);
    host_rd_in = 1'b1;
    @(negedge clk_in);
    host_rd_in = 1'b0;
    if (q.size() > 0) q.pop_front();
  endtask
  initial begin
    #400000;
    fails++;
    give_verdict();
  end
  initial begin
    seed = $urandom(32'hF0CCC221);
    repeat (12) @(negedge clk_in);
    rst_in = 1'b0;
    check(8'({fifo_empty_out, fifo_full_out}), 8'h02);
    // Only the fast set lives here; slower registers sit behind external data moves
    for (int i = 0; i < 16; i++) begin
      regs[i] = 8'($urandom);
      fast_addr_in = 4'(i);
      fast_wdata_in = regs[i];
      fast_we_in = 1'b1;
      @(negedge clk_in);
    end
    fast_we_in = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      fast_addr_in = 4'(i);
      repeat (2) @(negedge clk_in);
      check(fast_rdata_out, regs[i]);
    end
    // Fill past the top, then drain past the bottom
    for (int i = 0; i < 65; i++) wr(8'($urandom));
    check(8'(fifo_full_out), 8'h01);
    dir_tx_in = 1'b0;
    for (int i = 0; i < 65; i++) rd();
    check(8'({fifo_empty_out, fifo_full_out}), 8'h02);
    dir_tx_in = 1'b1;
    for (int i = 0; i < 3; i++) wr(8'($urandom));
    flush_in = 1'b1;
    @(negedge clk_in);
    flush_in = 1'b0;
    @(negedge clk_in);
    q.delete();
    check(8'(fifo_empty_out), 8'h01);
    // Two bytes plus two check bytes, nine bits each, at 106, 212 and 424 kbit/s
    for (int r = 0; r < 3; r++) begin
      rate_in = 2'(r);
      d = (r == 0 ? `DIV_106 : r == 1 ? `DIV_212 : `DIV_424) + 1;
      wr(8'($urandom));
      wr(8'($urandom));
      start_tx_in = 1'b1;
      @(negedge clk_in);
      start_tx_in = 1'b0;
      check(8'(tx_active_out), 8'h01);
      n = 0;
      while (tx_active_out === 1'b1 && n < 3000) begin
        @(negedge clk_in);
        n++;
      end
      check(8'(n >= 34 * d && n <= 40 * d), 8'h01);
      q.delete();
      check(8'(fifo_empty_out), 8'h01);
    end
    dir_tx_in = 1'b0;
    b = 8'($urandom);
    fe.frame(b, 1'b0);
    repeat (40) @(negedge clk_in);
    check(8'({field_seen, parity_err_out}), 8'h02);
    check(8'(done_cnt), 8'h01);
    check(8'(rx_scheme_out), 8'(`DM_TYPEA));
    q.push_back(b);
    rd();
    fe.frame(8'($urandom), 1'b1);
    repeat (40) @(negedge clk_in);
    check(8'({parity_err_out, field_on_out}), 8'h02);
    check(8'(done_cnt), 8'h02);
    give_verdict();
  end
endmodule
`default_nettype wire
